// >>> logic/rxm_map.svh
// register offsets, field positions, reset values and timing counts of the mode/self-test block
`ifndef RXM_MAP_SVH
`define RXM_MAP_SVH
`define RXM_ADDR_W 8
`define RXM_OFF_RX_MODE 8'h23
`define RXM_OFF_SELFTEST 8'h24
`define RXM_OFF_IRQ_STATUS 8'h30
`define RXM_OFF_IRQ_MASK 8'h31
`define RXM_OFF_PROTECT_STATUS 8'h32
`define RXM_OFF_CKSUM_COUNT 8'h33
`define RXM_BIT_CKSUM_EN 7
`define RXM_BIT_RATE_HALF 6
`define RXM_BIT_AUTO_AUDIO 5
`define RXM_BIT_BC_FAST 4
`define RXM_BIT_COAX 3
`define RXM_BIT_REPEATER 2
`define RXM_BIT_ST_PIN_CFG 3
`define RXM_BIT_ST_EN 0
`define RXM_RX_MODE_RST 8'h20
`define RXM_SELFTEST_RST 8'h08
`define RXM_REMOTE_CLKSRC_OFF 8'h14
`define RXM_IRQ_CKSUM 0
`define RXM_IRQ_FWD_DONE 1
`define RXM_BC_FAST_MBPS 20
`define RXM_CLK_MHZ 250
`define RXM_BC_FAST_DIV ((`RXM_CLK_MHZ + `RXM_BC_FAST_MBPS - 1) / `RXM_BC_FAST_MBPS)
`endif

// >>> logic/rxm_pkg.sv
// types of the receive-mode and self-test control block
package rxm_pkg;
  typedef enum logic [1:0] {RXM_OSC_50, RXM_OSC_25, RXM_OSC_10, RXM_OSC_RSV} rxm_osc_t;
  typedef enum logic [1:0] {RXM_FWD_IDLE, RXM_FWD_SEND, RXM_FWD_DONE} rxm_fwd_t;
endpackage : rxm_pkg

// >>> logic/rxm_rate_div.sv
// programmable divider that emits a one-cycle enable pulse every 'div' cycles
`timescale 1ns/1ns
module rxm_rate_div (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [9:0] i_div,
  output logic o_tick
);
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic tick_next;
  // count down and pulse on wrap
  always_comb begin
    tick_next = 1'b0;
    if (cnt_reg == 10'h000) begin
      tick_next = 1'b1;
      cnt_next = (i_div == 10'h000) ? 10'h000 : i_div - 10'h001;
    end else begin
      cnt_next = cnt_reg - 10'h001;
    end
  end
  // register counter and tick
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 10'h000;
      o_tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_tick <= tick_next;
    end
  end
endmodule : rxm_rate_div

// >>> logic/rxm_ctrl_regs.sv
// receive-mode and self-test control registers with checksum check and remote forwarding
`timescale 1ns/1ns
`include "rxm_map.svh"
// Behaviour
// - with the checksum enable set, the byte after each video line is compared to the line sum.
// - each checksum mismatch is recorded in the content-protection status register.
// - the rate-half bit sets back-channel divide-by-4 when 0 and divide-by-2 when 1.
// - the fast back-channel bit selects 20 Mbps and overrides the rate-half bit.
// - changing a back-channel rate may cause brief errors that are not suppressed.
// - the auto-audio bit resets to 1 and then audio mode follows received aux codes.
// - cable and fast bits load from the first mode strap pin and stay writable.
// - the cable bit selects twisted pair when 0 and coax when 1.
// - the repeater bit is read-only and reports the latched strap.
// - with auto clock on, bits 5-4 pick 50, 25 or 10 MHz, code 11 reserved.
// - the pin-config bit resets to 1, choosing pin setup, else bits 2:0 set self-test.
// - when self-test is enabled the clock-source field is written to remote offset 0x14.
// - clock-source 00 picks the external pixel clock, any other value the internal one.
module rxm_ctrl_regs import rxm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_mode_strap_pin_1,
  input wire logic i_repeater_strap,
  input wire logic i_auto_clock_en,
  input wire logic [7:0] i_osc_divider_setting,
  input wire logic i_selftest_pin_en,
  input wire logic [2:0] i_selftest_pin_cfg,
  input wire logic [1:0] i_aux_audio_mode,
  input wire logic [1:0] i_reg_audio_mode,
  input wire logic i_pix_valid,
  input wire logic [7:0] i_pix_byte,
  input wire logic i_line_end,
  input wire logic i_cksum_valid,
  input wire logic [7:0] i_cksum_byte,
  input wire logic i_remote_ready,
  output logic o_remote_wr,
  output logic [7:0] o_remote_addr,
  output logic [7:0] o_remote_wdata,
  output logic o_bc_tick,
  output logic o_bc_fast,
  output logic o_coax_mode,
  output logic [1:0] o_audio_mode,
  output logic [1:0] o_osc_rx_clock_rate,
  output logic o_osc_clock_on,
  output logic o_selftest_en,
  output logic o_selftest_internal_clk,
  output logic o_irq
);
  logic [7:0] rx_mode_reg;
  logic [7:0] rx_mode_next;
  logic [7:0] selftest_reg;
  logic [7:0] selftest_next;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_mask_next;
  logic [7:0] protect_status_reg;
  logic [7:0] protect_status_next;
  logic [7:0] cksum_count_reg;
  logic [7:0] cksum_count_next;
  logic repeater_reg;
  logic repeater_next;
  logic strap_done_reg;
  logic strap_done_next;
  logic [7:0] line_sum_reg;
  logic [7:0] line_sum_next;
  logic cksum_pend_reg;
  logic cksum_pend_next;
  logic cksum_err;
  logic [7:0] rdata_next;
  rxm_fwd_t fwd_reg;
  rxm_fwd_t fwd_next;
  logic [7:0] fwd_data_reg;
  logic [7:0] fwd_data_next;
  logic st_en_d_reg;
  logic fwd_done_evt;
  logic [9:0] bc_div;
  logic st_en_eff;
  logic [2:0] st_cfg_eff;

  // self-test setup comes from the pin or from the register field
  always_comb begin
    if (selftest_reg[`RXM_BIT_ST_PIN_CFG]) begin
      st_en_eff = i_selftest_pin_en;
      st_cfg_eff = i_selftest_pin_cfg;
    end else begin
      st_en_eff = selftest_reg[`RXM_BIT_ST_EN];
      st_cfg_eff = selftest_reg[2:0];
    end
  end

  // back-channel period: RXM_BC_FAST_DIV when fast, else osc divider times 2 or 4, so divide-by-4 is the slower rate
  always_comb begin
    if (rx_mode_reg[`RXM_BIT_BC_FAST]) begin
      bc_div = 10'(`RXM_BC_FAST_DIV);
    end else if (rx_mode_reg[`RXM_BIT_RATE_HALF]) begin
      bc_div = {1'b0, i_osc_divider_setting, 1'b0};
    end else begin
      bc_div = {i_osc_divider_setting, 2'b00};
    end
  end

  // rate changes take effect at the divider's next reload after the current count; transient link errors are tolerated
  rxm_rate_div u_bc_div (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_div(bc_div),
    .o_tick(o_bc_tick)
  );

  // line checksum accumulation and compare
  always_comb begin
    line_sum_next = line_sum_reg;
    cksum_pend_next = cksum_pend_reg;
    cksum_err = 1'b0;
    if (i_pix_valid) begin
      line_sum_next = line_sum_reg + i_pix_byte;
    end
    if (i_line_end) begin
      cksum_pend_next = rx_mode_reg[`RXM_BIT_CKSUM_EN];
    end
    if (i_cksum_valid && cksum_pend_reg) begin
      cksum_err = (i_cksum_byte != line_sum_reg);
      cksum_pend_next = 1'b0;
      line_sum_next = 8'h00;
    end else if (i_cksum_valid) begin
      line_sum_next = 8'h00;
    end
  end

  // forward clock-source field to the remote serializer on self-test enable
  always_comb begin
    fwd_next = fwd_reg;
    fwd_data_next = fwd_data_reg;
    fwd_done_evt = 1'b0;
    case (fwd_reg)
      RXM_FWD_IDLE: begin
        if (st_en_eff && !st_en_d_reg) begin
          fwd_data_next = {6'h00, st_cfg_eff[2:1]};
          fwd_next = RXM_FWD_SEND;
        end
      end
      RXM_FWD_SEND: begin
        if (i_remote_ready) begin
          fwd_next = RXM_FWD_DONE;
        end
      end
      RXM_FWD_DONE: begin
        fwd_done_evt = 1'b1;
        fwd_next = RXM_FWD_IDLE;
      end
      default: begin
        fwd_next = RXM_FWD_IDLE;
      end
    endcase
  end

  // register file writes, strap capture and event flags
  always_comb begin
    rx_mode_next = rx_mode_reg;
    selftest_next = selftest_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    protect_status_next = protect_status_reg;
    cksum_count_next = cksum_count_reg;
    repeater_next = repeater_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      rx_mode_next[`RXM_BIT_BC_FAST] = i_mode_strap_pin_1;
      rx_mode_next[`RXM_BIT_COAX] = i_mode_strap_pin_1;
      repeater_next = i_repeater_strap;
    end
    if (i_wr) begin
      case (i_addr)
        `RXM_OFF_RX_MODE: begin
          rx_mode_next = i_wdata; // reserved bits stored, unused
        end
        `RXM_OFF_SELFTEST: begin
          selftest_next = i_wdata;
        end
        `RXM_OFF_IRQ_MASK: begin
          irq_mask_next = i_wdata;
        end
        `RXM_OFF_IRQ_STATUS: begin
          irq_status_next = irq_status_reg & ~i_wdata;
        end
        `RXM_OFF_PROTECT_STATUS: begin
          protect_status_next = protect_status_reg & ~i_wdata;
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over a same-cycle clear
    if (cksum_err) begin
      protect_status_next[0] = 1'b1;
      irq_status_next[`RXM_IRQ_CKSUM] = 1'b1;
      if (cksum_count_reg != 8'hff) begin
        cksum_count_next = cksum_count_reg + 8'h01;
      end
    end
    if (fwd_done_evt) begin
      irq_status_next[`RXM_IRQ_FWD_DONE] = 1'b1;
    end
  end

  // read mux, data one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `RXM_OFF_RX_MODE: begin
          rdata_next = rx_mode_reg;
          rdata_next[`RXM_BIT_REPEATER] = repeater_reg;
        end
        `RXM_OFF_SELFTEST: rdata_next = selftest_reg;
        `RXM_OFF_IRQ_STATUS: rdata_next = irq_status_reg;
        `RXM_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
        `RXM_OFF_PROTECT_STATUS: rdata_next = protect_status_reg;
        `RXM_OFF_CKSUM_COUNT: rdata_next = cksum_count_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_mode_reg <= `RXM_RX_MODE_RST;
      selftest_reg <= `RXM_SELFTEST_RST;
      irq_status_reg <= 8'h00;
      irq_mask_reg <= 8'h00;
      protect_status_reg <= 8'h00;
      cksum_count_reg <= 8'h00;
      repeater_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      line_sum_reg <= 8'h00;
      cksum_pend_reg <= 1'b0;
      o_rdata <= 8'h00;
      fwd_reg <= RXM_FWD_IDLE;
      fwd_data_reg <= 8'h00;
      st_en_d_reg <= 1'b0;
    end else begin
      rx_mode_reg <= rx_mode_next;
      selftest_reg <= selftest_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      protect_status_reg <= protect_status_next;
      cksum_count_reg <= cksum_count_next;
      repeater_reg <= repeater_next;
      strap_done_reg <= strap_done_next;
      line_sum_reg <= line_sum_next;
      cksum_pend_reg <= cksum_pend_next;
      o_rdata <= rdata_next;
      fwd_reg <= fwd_next;
      fwd_data_reg <= fwd_data_next;
      st_en_d_reg <= st_en_eff;
    end
  end

  // mode outputs
  assign o_bc_fast = rx_mode_reg[`RXM_BIT_BC_FAST];
  assign o_coax_mode = rx_mode_reg[`RXM_BIT_COAX];
  assign o_audio_mode = rx_mode_reg[`RXM_BIT_AUTO_AUDIO] ?
    i_aux_audio_mode : i_reg_audio_mode;
  assign o_osc_rx_clock_rate = selftest_reg[5:4];
  assign o_osc_clock_on = i_auto_clock_en && (selftest_reg[5:4] != 2'(RXM_OSC_RSV));
  assign o_selftest_en = st_en_eff;
  assign o_selftest_internal_clk = (st_cfg_eff[2:1] != 2'b00);
  assign o_remote_wr = (fwd_reg == RXM_FWD_SEND);
  assign o_remote_addr = `RXM_REMOTE_CLKSRC_OFF;
  assign o_remote_wdata = fwd_data_reg;
  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // checks
  property p_fast_override;
    @(posedge i_clk) disable iff (!i_arst_n)
    rx_mode_reg[`RXM_BIT_BC_FAST] |-> bc_div == 10'(`RXM_BC_FAST_DIV);
  endproperty
  a_fast_override: assert property (p_fast_override) else $error("fast rate not used");
  property p_half_rate;
    @(posedge i_clk) disable iff (!i_arst_n)
    (!rx_mode_reg[4] && rx_mode_reg[6]) |-> bc_div == {1'b0, i_osc_divider_setting, 1'b0};
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("divide-by-2 wrong");
  property p_cksum_flag;
    @(posedge i_clk) disable iff (!i_arst_n)
    cksum_err |=> protect_status_reg[0] && irq_status_reg[`RXM_IRQ_CKSUM];
  endproperty
  a_cksum_flag: assert property (p_cksum_flag) else $error("mismatch not recorded");
  property p_protect_sticky;
    @(posedge i_clk) disable iff (!i_arst_n)
    protect_status_reg[0] && !(i_wr && i_addr == `RXM_OFF_PROTECT_STATUS && i_wdata[0])
      |=> protect_status_reg[0];
  endproperty
  a_protect_sticky: assert property (p_protect_sticky) else $error("failure flag lost");
  property p_cksum_gate;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_line_end && !rx_mode_reg[7]) |=> !cksum_pend_reg;
  endproperty
  a_cksum_gate: assert property (p_cksum_gate) else $error("check while disabled");
  property p_strap_load;
    @(posedge i_clk) disable iff (!i_arst_n)
    !strap_done_reg && !i_wr |=> rx_mode_reg[4] == $past(i_mode_strap_pin_1)
      && rx_mode_reg[3] == rx_mode_reg[4];
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded");
  property p_repeater_ro;
    @(posedge i_clk) disable iff (!i_arst_n)
    strap_done_reg |=> $stable(repeater_reg);
  endproperty
  a_repeater_ro: assert property (p_repeater_ro) else $error("repeater bit changed");
  property p_fwd_start;
    @(posedge i_clk) disable iff (!i_arst_n)
    (fwd_reg == RXM_FWD_IDLE && st_en_eff && !st_en_d_reg)
      |=> o_remote_wr && o_remote_wdata[1:0] == $past(st_cfg_eff[2:1]);
  endproperty
  a_fwd_start: assert property (p_fwd_start) else $error("clock source not forwarded");
  property p_fwd_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_remote_wr && !i_remote_ready) |=> o_remote_wr && $stable(o_remote_wdata);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("remote write dropped");
  property p_fwd_irq;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_remote_wr && i_remote_ready) |=> ##1 irq_status_reg[`RXM_IRQ_FWD_DONE];
  endproperty
  a_fwd_irq: assert property (p_fwd_irq) else $error("forward done not flagged");
  property p_auto_audio;
    @(posedge i_clk) disable iff (!i_arst_n)
    rx_mode_reg[`RXM_BIT_AUTO_AUDIO] |-> o_audio_mode == i_aux_audio_mode;
  endproperty
  a_auto_audio: assert property (p_auto_audio) else $error("aux audio code ignored");
  property p_osc_reserved;
    @(posedge i_clk) disable iff (!i_arst_n)
    (selftest_reg[5:4] == 2'b11) |-> !o_osc_clock_on;
  endproperty
  a_osc_reserved: assert property (p_osc_reserved) else $error("reserved rate used");
  property p_pin_cfg;
    @(posedge i_clk) disable iff (!i_arst_n)
    selftest_reg[3] |-> o_selftest_en == i_selftest_pin_en;
  endproperty
  a_pin_cfg: assert property (p_pin_cfg) else $error("pin config ignored");
endmodule : rxm_ctrl_regs

// >>> testbench/rxm_remote_ser_model.sv
// behavioural remote serializer that takes forwarded register writes
`timescale 1ns/1ns
module rxm_remote_ser_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0] i_delay,
  output logic o_ready,
  output logic [7:0] o_last_addr,
  output logic [7:0] o_last_data,
  output int o_count
);
  int wait_cnt;
  // answers a held write after i_delay cycles with no reply from its far end
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready <= 1'b0;
      wait_cnt <= 0;
      o_count <= 0;
      o_last_addr <= 8'h00;
      o_last_data <= 8'h00;
    end else if (o_ready) begin
      o_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (i_wr) begin
      if (wait_cnt >= int'(i_delay)) begin
        o_ready <= 1'b1;
        o_last_addr <= i_addr;
        o_last_data <= i_wdata;
        o_count <= o_count + 1;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : rxm_remote_ser_model

// >>> testbench/tb_rxm_ctrl_regs.sv
// testbench of the receive-mode and self-test control registers
`timescale 1ns/1ns
`include "rxm_map.svh"
module tb_rxm_ctrl_regs;
  logic i_clk, i_arst_n, i_wr, i_rd, i_mode_strap_pin_1, i_repeater_strap, i_auto_clock_en;
  logic i_selftest_pin_en, i_pix_valid, i_line_end, i_cksum_valid, i_remote_ready, irq_a;
  logic [7:0] i_addr, i_wdata, o_rdata, i_osc_divider_setting, i_pix_byte, i_cksum_byte;
  logic [7:0] o_remote_addr, o_remote_wdata, last_addr, last_data;
  logic [2:0] i_selftest_pin_cfg;
  logic [1:0] i_aux_audio_mode, i_reg_audio_mode, o_audio_mode, o_osc_rx_clock_rate;
  logic o_remote_wr, o_bc_tick, o_bc_fast, o_coax_mode, o_osc_clock_on, o_selftest_en;
  logic o_selftest_internal_clk, o_irq;
  logic [3:0] delay;
  int mismatches, n_compared, cycles, fwd_count, p0, p1;

  rxm_ctrl_regs i_dut (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_mode_strap_pin_1, .i_repeater_strap, .i_auto_clock_en, .i_osc_divider_setting,
    .i_selftest_pin_en, .i_selftest_pin_cfg, .i_aux_audio_mode, .i_reg_audio_mode,
    .i_pix_valid, .i_pix_byte, .i_line_end, .i_cksum_valid, .i_cksum_byte, .i_remote_ready,
    .o_remote_wr, .o_remote_addr, .o_remote_wdata, .o_bc_tick, .o_bc_fast, .o_coax_mode,
    .o_audio_mode, .o_osc_rx_clock_rate, .o_osc_clock_on, .o_selftest_en,
    .o_selftest_internal_clk, .o_irq);

  rxm_remote_ser_model i_ser (.i_clk, .i_arst_n, .i_wr(o_remote_wr), .i_addr(o_remote_addr),
    .i_wdata(o_remote_wdata), .i_delay(delay), .o_ready(i_remote_ready),
    .o_last_addr(last_addr), .o_last_data(last_data), .o_count(fwd_count));

  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // cuts a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 cmp8(o_rdata, exp, what);
  endtask : rd

  // one line of bytes 01 and 02, then the checksum byte
  task automatic line(input logic [7:0] ck);
    @(posedge i_clk);
    i_pix_valid <= 1'b1;
    i_pix_byte <= 8'h01;
    @(posedge i_clk);
    i_pix_byte <= 8'h02;
    @(posedge i_clk);
    i_pix_valid <= 1'b0;
    i_line_end <= 1'b1;
    @(posedge i_clk);
    i_line_end <= 1'b0;
    i_cksum_valid <= 1'b1;
    i_cksum_byte <= ck;
    @(posedge i_clk);
    i_cksum_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : line

  // cycles between two back-channel ticks
  task automatic gap(output int n);
    int c;
    c = 0;
    @(negedge i_clk);
    while (o_bc_tick !== 1'b1 && c < 400) begin
      @(negedge i_clk);
      c++;
    end
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_bc_tick !== 1'b1 && n < 400);
  endtask : gap

  task automatic wait_fwd(input int n);
    int c;
    c = 0;
    while (fwd_count != n && c < 50) begin
      @(negedge i_clk);
      c++;
    end
    cmp8(8'(fwd_count), 8'(n), "forward count");
  endtask : wait_fwd

  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_mode_strap_pin_1 = 1'b1;
    i_repeater_strap = 1'b1;
    i_auto_clock_en = 1'b1;
    i_osc_divider_setting = 8'h10;
    i_selftest_pin_en = 1'b0;
    i_selftest_pin_cfg = 3'h0;
    i_aux_audio_mode = 2'h2;
    i_reg_audio_mode = 2'h1;
    i_pix_valid = 1'b0;
    i_pix_byte = 8'h00;
    i_line_end = 1'b0;
    i_cksum_valid = 1'b0;
    i_cksum_byte = 8'h00;
    delay = 4'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(8'h23, 8'h3c, "mode reset");
    rd(8'h24, 8'h08, "selftest reset");
    cmp8({6'h0, o_bc_fast, o_coax_mode}, 8'h03, "strap outputs");
    cmp8({6'h0, o_audio_mode}, 8'h02, "aux audio");
    $display("test reset done");
    wr(8'h23, 8'h03);
    rd(8'h23, 8'h07, "mode write");
    cmp8({6'h0, o_bc_fast, o_coax_mode}, 8'h00, "twisted pair");
    cmp8({6'h0, o_audio_mode}, 8'h01, "reg audio");
    wr(8'h23, 8'h08);
    cmp8({7'h0, o_coax_mode}, 8'h01, "coax");
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00, "unmapped");
    $display("test mode bits done");
    wr(8'h23, 8'h00);
    gap(p0);
    gap(p0);
    wr(8'h23, 8'h40);
    gap(p1);
    gap(p1);
    cmp8(8'(p0 == 2 * p1), 8'h01, "rate half");
    wr(8'h23, 8'h10);
    gap(p0);
    gap(p0);
    cmp8(8'(p0), 8'(`RXM_BC_FAST_DIV), "fast rate");
    wr(8'h23, 8'h50);
    gap(p1);
    gap(p1);
    cmp8(8'(p1), 8'(`RXM_BC_FAST_DIV), "fast overrides half");
    $display("test back channel done");
    for (int f = 0; f < 4; f++) begin
      wr(8'h24, {2'h0, 2'(f), 4'h8});
      cmp8({6'h0, o_osc_rx_clock_rate}, 8'(f), "osc rate");
      cmp8({7'h0, o_osc_clock_on}, 8'(f != 3), "osc on");
    end
    wr(8'h24, 8'h08);
    @(posedge i_clk);
    i_auto_clock_en <= 1'b0;
    @(negedge i_clk);
    cmp8({7'h0, o_osc_clock_on}, 8'h00, "osc off");
    @(posedge i_clk);
    i_auto_clock_en <= 1'b1;
    i_selftest_pin_en <= 1'b1;
    @(negedge i_clk);
    cmp8({7'h0, o_selftest_en}, 8'h01, "pin selftest");
    wait_fwd(1);
    @(posedge i_clk);
    i_selftest_pin_en <= 1'b0;
    for (int cs = 0; cs < 4; cs++) begin
      delay = 4'(cs);
      wr(8'h24, {5'h0, 2'(cs), 1'b1});
      cmp8({7'h0, o_selftest_internal_clk}, 8'(cs != 0), "clock source");
      wait_fwd(cs + 2);
      cmp8(last_addr, 8'h14, "remote offset");
      cmp8(last_data, 8'(cs), "remote source");
      wr(8'h24, 8'h00);
    end
    rd(8'h30, 8'h02, "forward done");
    wr(8'h30, 8'h02);
    rd(8'h30, 8'h00, "status cleared");
    $display("test self-test done");
    wr(8'h31, 8'hff);
    line(8'h04);
    rd(8'h32, 8'h00, "check off");
    wr(8'h23, 8'h80);
    line(8'h03);
    rd(8'h32, 8'h00, "good sum");
    line(8'h04);
    rd(8'h32, 8'h01, "bad sum");
    rd(8'h33, 8'h01, "mismatch count");
    irq_a = o_irq;
    wr(8'h31, 8'h00);
    cmp8({7'h0, irq_a ^ o_irq}, 8'h01, "irq mask");
    wr(8'h32, 8'h01);
    wr(8'h30, 8'h01);
    wr(8'h31, 8'hff);
    cmp8({7'h0, o_irq}, 8'h00, "irq cleared");
    $display("test checksum done");
    final_report();
  end
endmodule : tb_rxm_ctrl_regs
